// *** core/rcs_recov_clock_sel.sv ***
`timescale 1ns/100ps
`include "rcs_params.svh"

module rcs_recov_clock_sel
   import rcs_pkg::*;
#(
   parameter int NSRC = `RCS_NSRC,
   parameter int NCHAN = `RCS_NCHAN,
   parameter int NEXT = `RCS_NEXT
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,

   // Register port
   input wire logic [`RCS_ADDR_W-1:0] i_reg_addr,
   input wire logic [`RCS_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [`RCS_DATA_W-1:0] o_reg_rdata,

   // Source edge ticks, loss of signal, PLL lock
   input wire logic [NSRC-1:0] i_src_tick,
   input wire logic [NSRC-1:0] i_src_los,
   input wire logic [`RCS_NPLL-1:0] i_pll_locked,

   // Recovered clocks
   output logic [NEXT-1:0] o_recov_out,
   output logic [NEXT-1:0] o_recov_out_sel,
   output logic [NCHAN-NEXT-1:0] o_recov_int,
   output logic [`RCS_NPLL-1:0] o_pll_diff_out
);
   typedef struct packed {
      rcs_chan_cfg_t [NCHAN-1:0] chan;
      logic [`RCS_NPLL-1:0] pll_squelch_enable;
      logic [3:0] pll_output_freq_select;
      rcs_cu_ctrl_t copper1_recov_ctrl;
      rcs_cu_ctrl_t copper0_recov_ctrl;
      logic [4:0] sd1g_squelch_enable;
      logic [1:0] sd6g_squelch_enable;
      logic [`RCS_DATA_W-1:0] rdata;
   } rcs_top_state_t;

   rcs_top_state_t state_ff;
   rcs_top_state_t nxt_state;

   logic [NSRC-1:0] eff_tick;
   logic [NSRC-1:0] squelch;
   logic [NCHAN-1:0] ch_clk;
   logic [NCHAN-1:0] ch_run;
   logic [NCHAN-1:0] ch_sq;
   logic [`RCS_NPLL-1:0] pll_clk;
   logic [`RCS_NPLL-1:0] pll_run;
   logic [`RCS_NPLL-1:0] pll_sq;
   logic [`RCS_DATA_W-1:0] status_word;
   logic [`RCS_DATA_W-1:0] read_word;

   // Divider code to ratio; code 1 gives 31.25 MHz, code 6 gives 125 MHz
   function automatic logic [`RCS_DIV_W-1:0] div_ratio(input logic [2:0] code);
      logic [`RCS_DIV_W-1:0] r;
      r = `RCS_DIVC_RSVD;
      unique case (code)
         3'h0: r = `RCS_DIVC_0;
         3'h1: r = `RCS_DIVC_1;
         3'h2: r = `RCS_DIVC_2;
         3'h3: r = `RCS_DIVC_3;
         3'h4: r = `RCS_DIVC_4;
         3'h5: r = `RCS_DIVC_5;
         3'h6: r = `RCS_DIVC_6;
         3'h7: r = `RCS_DIVC_RSVD;
      endcase
      return r;
   endfunction

   // PLL output select: off, straight through, half, quarter
   function automatic logic [`RCS_DIV_W-1:0] pll_ratio(input logic [1:0] sel);
      logic [`RCS_DIV_W-1:0] r;
      r = `RCS_DIVC_6;
      unique case (sel)
         2'h0: r = `RCS_DIVC_6;
         2'h1: r = `RCS_DIVC_6;
         2'h2: r = `RCS_DIVC_0;
         2'h3: r = `RCS_DIVC_1;
      endcase
      return r;
   endfunction

   // Copper ticks pass only when the PHY control routes that PHY out
   always_comb begin
      eff_tick = i_src_tick;
      eff_tick[`RCS_SRC_CU0] = i_src_tick[`RCS_SRC_CU0]
         & state_ff.copper0_recov_ctrl.copper_recov_enable
         & (state_ff.copper0_recov_ctrl.copper_source_select == 1'b0)
         & state_ff.copper0_recov_ctrl.copper_freq_select
         & state_ff.copper0_recov_ctrl.copper_phy_select;
      eff_tick[`RCS_SRC_CU1] = i_src_tick[`RCS_SRC_CU1]
         & state_ff.copper1_recov_ctrl.copper_recov_enable
         & (state_ff.copper1_recov_ctrl.copper_source_select == 1'b1)
         & state_ff.copper1_recov_ctrl.copper_freq_select
         & state_ff.copper1_recov_ctrl.copper_phy_select;
   end

   // Squelch requests per source code, one cycle behind the loss inputs
   rcs_squelch_map #(
      .NSRC(NSRC)
   ) u_squelch (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_src_los(i_src_los),
      .i_pll_locked(i_pll_locked),
      .i_sd1g_sq_en(state_ff.sd1g_squelch_enable),
      .i_sd6g_sq_en(state_ff.sd6g_squelch_enable),
      .i_pll_sq_en(state_ff.pll_squelch_enable),
      .o_squelch(squelch)
   );

   // One divider per channel; the source mux inside covers codes 12 and 21
   generate
      for (genvar c = 0; c < NCHAN; c++) begin : g_chan
         rcs_clk_div #(
            .NSRC(NSRC)
         ) u_div (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_ticks(eff_tick),
            .i_squelch(squelch),
            .i_enable(state_ff.chan[c].channel_enable),
            .i_src(state_ff.chan[c].channel_source),
            .i_div_val(div_ratio(state_ff.chan[c].channel_divider)),
            .o_clk(ch_clk[c]),
            .o_running(ch_run[c]),
            .o_squelched(ch_sq[c])
         );
      end
   endgenerate

   // Differential PLL outputs reuse the divider with a fixed source
   generate
      for (genvar p = 0; p < `RCS_NPLL; p++) begin : g_pll
         rcs_clk_div #(
            .NSRC(NSRC)
         ) u_pll_div (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_ticks(eff_tick),
            .i_squelch(squelch),
            .i_enable(state_ff.pll_output_freq_select[2*p +: 2] != 2'h0),
            .i_src((p == 0) ? `RCS_SRC_PLL0 : `RCS_SRC_PLL1),
            .i_div_val(pll_ratio(state_ff.pll_output_freq_select[2*p +: 2])),
            .o_clk(pll_clk[p]),
            .o_running(pll_run[p]),
            .o_squelched(pll_sq[p])
         );
      end
   endgenerate

   // Live status: clock levels, running, squelched, PLL lock
   always_comb begin
      status_word = '0;
      status_word[7:0] = ch_clk;
      status_word[15:8] = ch_run;
      status_word[23:16] = ch_sq;
      status_word[25:24] = pll_clk;
      status_word[27:26] = pll_run;
      status_word[29:28] = pll_sq;
      status_word[31:30] = i_pll_locked;
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      read_word = '0;
      if (i_reg_addr <= `RCS_A_CHAN_LAST) begin
         read_word[$bits(rcs_chan_cfg_t)-1:0] = state_ff.chan[i_reg_addr[2:0]];
      end else begin
         unique case (i_reg_addr)
            `RCS_A_PLL0: read_word[0] = state_ff.pll_squelch_enable[0];
            `RCS_A_PLL1: read_word[0] = state_ff.pll_squelch_enable[1];
            `RCS_A_CLKOUT: read_word[3:0] = state_ff.pll_output_freq_select;
            `RCS_A_CU0: read_word[3:0] = state_ff.copper0_recov_ctrl;
            `RCS_A_CU1: read_word[3:0] = state_ff.copper1_recov_ctrl;
            `RCS_A_SDSQ: read_word[6:0] = {state_ff.sd6g_squelch_enable,
                                           state_ff.sd1g_squelch_enable};
            `RCS_A_STATUS: read_word = status_word;
            default: read_word = '0;
         endcase
      end
   end

   // Register writes and the one-cycle read return
   always_comb begin
      nxt_state = state_ff;
      nxt_state.rdata = i_reg_rd ? read_word : `RCS_RST_WORD;
      if (i_reg_wr) begin
         if (i_reg_addr <= `RCS_A_CHAN_LAST) begin
            nxt_state.chan[i_reg_addr[2:0]] =
               rcs_chan_cfg_t'(i_reg_wdata[$bits(rcs_chan_cfg_t)-1:0]);
         end else begin
            unique case (i_reg_addr)
               `RCS_A_PLL0: nxt_state.pll_squelch_enable[0] = i_reg_wdata[0];
               `RCS_A_PLL1: nxt_state.pll_squelch_enable[1] = i_reg_wdata[0];
               `RCS_A_CLKOUT: nxt_state.pll_output_freq_select = i_reg_wdata[3:0];
               `RCS_A_CU0: nxt_state.copper0_recov_ctrl = rcs_cu_ctrl_t'(i_reg_wdata[3:0]);
               `RCS_A_CU1: nxt_state.copper1_recov_ctrl = rcs_cu_ctrl_t'(i_reg_wdata[3:0]);
               `RCS_A_SDSQ: begin
                  nxt_state.sd1g_squelch_enable = i_reg_wdata[4:0];
                  nxt_state.sd6g_squelch_enable = i_reg_wdata[6:5];
               end
               default: ;
            endcase
         end
      end
   end

   // All configuration clears on reset, so every channel starts static low
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Entries 0-3 drive the pin overlays, 4-7 stay inside
   always_comb begin
      for (int k = 0; k < NEXT; k++) begin
         o_recov_out[k] = ch_clk[k];
         o_recov_out_sel[k] = state_ff.chan[k].channel_enable;
      end
      o_recov_int = ch_clk[NCHAN-1:NEXT];
   end

   assign o_pll_diff_out = pll_clk;
   assign o_reg_rdata = state_ff.rdata;
endmodule

// *** core/rcs_params.svh ***
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// Channel and source counts
`define RCS_NCHAN 8
`define RCS_NEXT 4
`define RCS_NPLL 2
`define RCS_NSRC 22
`define RCS_SRC_W 5
`define RCS_DIV_W 5

// Source codes
`define RCS_SRC_CU0 5'h00
`define RCS_SRC_CU1 5'h01
`define RCS_SRC_SD1G_LO 5'h04
`define RCS_SRC_SD1G_HI 5'h08
`define RCS_SRC_SD6G_LO 5'h09
`define RCS_SRC_SD6G_HI 5'h0A
`define RCS_SRC_PLL0 5'h0C
`define RCS_SRC_PLL1 5'h15

// Divider code to division ratio
`define RCS_DIVC_0 5'h02
`define RCS_DIVC_1 5'h04
`define RCS_DIVC_2 5'h08
`define RCS_DIVC_3 5'h10
`define RCS_DIVC_4 5'h05
`define RCS_DIVC_5 5'h19
`define RCS_DIVC_6 5'h01
`define RCS_DIVC_RSVD 5'h01

// Register word addresses
`define RCS_ADDR_W 5
`define RCS_A_CHAN_LAST 5'h07
`define RCS_A_PLL0 5'h08
`define RCS_A_PLL1 5'h09
`define RCS_A_CLKOUT 5'h0A
`define RCS_A_CU0 5'h0B
`define RCS_A_CU1 5'h0C
`define RCS_A_SDSQ 5'h0D
`define RCS_A_STATUS 5'h0E
`define RCS_DATA_W 32
`define RCS_RST_WORD 32'h0000_0000

`endif

// *** core/rcs_pkg.sv ***
`include "rcs_params.svh"

package rcs_pkg;
   // One recovered-clock channel configuration entry
   typedef struct packed {
      logic [`RCS_SRC_W-1:0] channel_source;
      logic [2:0] channel_divider;
      logic channel_enable;
   } rcs_chan_cfg_t;

   // Copper PHY recovered clock control
   typedef struct packed {
      logic copper_phy_select;
      logic copper_freq_select;
      logic copper_source_select;
      logic copper_recov_enable;
   } rcs_cu_ctrl_t;
endpackage

// *** core/rcs_squelch_map.sv ***
`timescale 1ns/100ps
`include "rcs_params.svh"

module rcs_squelch_map
   import rcs_pkg::*;
#(
   parameter int NSRC = `RCS_NSRC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Loss indications
   input wire logic [NSRC-1:0] i_src_los,
   input wire logic [`RCS_NPLL-1:0] i_pll_locked,
   // Squelch enables
   input wire logic [4:0] i_sd1g_sq_en,
   input wire logic [1:0] i_sd6g_sq_en,
   input wire logic [`RCS_NPLL-1:0] i_pll_sq_en,
   // Per source squelch request
   output logic [NSRC-1:0] o_squelch
);
   typedef struct packed {
      logic [NSRC-1:0] sq;
   } rcs_sq_state_t;

   rcs_sq_state_t state_ff;
   rcs_sq_state_t nxt_state;

   // Copper sources have no squelch control and are never stopped here
   always_comb begin
      logic [`RCS_SRC_W-1:0] code;
      code = '0;
      nxt_state = '0;
      for (int i = 0; i < NSRC; i++) begin
         code = `RCS_SRC_W'(i);
         if (code >= `RCS_SRC_SD1G_LO && code <= `RCS_SRC_SD1G_HI) begin
            nxt_state.sq[i] = i_src_los[i] & i_sd1g_sq_en[3'(code - `RCS_SRC_SD1G_LO)];
         end else if (code >= `RCS_SRC_SD6G_LO && code <= `RCS_SRC_SD6G_HI) begin
            nxt_state.sq[i] = i_src_los[i] & i_sd6g_sq_en[1'(code - `RCS_SRC_SD6G_LO)];
         end else if (code == `RCS_SRC_PLL0) begin
            nxt_state.sq[i] = ~i_pll_locked[0] & i_pll_sq_en[0];
         end else if (code == `RCS_SRC_PLL1) begin
            nxt_state.sq[i] = ~i_pll_locked[1] & i_pll_sq_en[1];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_squelch = state_ff.sq;
endmodule

// *** core/rcs_clk_div.sv ***
`timescale 1ns/100ps
`include "rcs_params.svh"

module rcs_clk_div
   import rcs_pkg::*;
#(
   parameter int NSRC = `RCS_NSRC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Source edge ticks and squelch
   input wire logic [NSRC-1:0] i_ticks,
   input wire logic [NSRC-1:0] i_squelch,
   // Requested setup
   input wire logic i_enable,
   input wire logic [`RCS_SRC_W-1:0] i_src,
   input wire logic [`RCS_DIV_W-1:0] i_div_val,
   // Clock out and state
   output logic o_clk,
   output logic o_running,
   output logic o_squelched
);
   typedef struct packed {
      logic out;
      logic run;
      logic [`RCS_DIV_W-1:0] cnt;
      logic [`RCS_DIV_W-1:0] div;
      logic [`RCS_SRC_W-1:0] src;
   } rcs_div_state_t;

   rcs_div_state_t state_ff;
   rcs_div_state_t nxt_state;
   logic src_ok;
   logic sq;
   logic tick;

   // Unknown source codes give no ticks and never squelch
   assign src_ok = int'(state_ff.src) < NSRC;
   assign sq = state_ff.run & src_ok & i_squelch[state_ff.src];
   assign tick = state_ff.run & src_ok & i_ticks[state_ff.src];

   // Setup is only taken while low or while squelched, so a change never makes a runt
   always_comb begin
      nxt_state = state_ff;
      if (!state_ff.run) begin
         if (i_enable) begin
            nxt_state.run = 1'b1;
            nxt_state.src = i_src;
            nxt_state.div = i_div_val;
            nxt_state.cnt = '0;
         end
      end else if (sq) begin
         // Frozen at current level; picks up again when squelch drops
         nxt_state.cnt = '0;
         nxt_state.src = i_src;
         nxt_state.div = i_div_val;
         nxt_state.run = i_enable | state_ff.out;
      end else if (!i_enable && !state_ff.out) begin
         nxt_state.run = 1'b0;
         nxt_state.cnt = '0;
      end else if (tick) begin
         if (state_ff.cnt >= state_ff.div - `RCS_DIV_W'(1)) begin
            nxt_state.cnt = '0;
            nxt_state.out = ~state_ff.out;
            if (state_ff.out) begin
               nxt_state.src = i_src;
               nxt_state.div = i_div_val;
               nxt_state.run = i_enable;
            end
         end else begin
            nxt_state.cnt = state_ff.cnt + `RCS_DIV_W'(1);
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_clk = state_ff.out;
   assign o_running = state_ff.run;
   assign o_squelched = sq;
endmodule

// *** tb/rcs_recov_clock_sel_sva.sv ***
`timescale 1ns/100ps
`include "rcs_params.svh"

module rcs_recov_clock_sel_chk
   import rcs_pkg::*;
#(
   parameter int NSRC = `RCS_NSRC,
   parameter int NCHAN = `RCS_NCHAN,
   parameter int NEXT = `RCS_NEXT
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Register port
   input wire logic [`RCS_ADDR_W-1:0] i_reg_addr,
   input wire logic [`RCS_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [`RCS_DATA_W-1:0] o_reg_rdata,
   // Sources and clocks
   input wire logic [NSRC-1:0] i_src_tick,
   input wire logic [`RCS_NPLL-1:0] i_pll_locked,
   input wire logic [NEXT-1:0] o_recov_out,
   input wire logic [NEXT-1:0] o_recov_out_sel,
   input wire logic [NCHAN-NEXT-1:0] o_recov_int
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   // Read data is zero outside the cycle after a read
   property p_rdata_idle;
      !$past(i_reg_rd) |-> o_reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_unmapped;
      i_reg_rd && i_reg_addr > 5'h0E |=> o_reg_rdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // Write, idle cycle, read back of the same channel entry
   property p_chan_rd;
      i_reg_wr && i_reg_addr <= 5'h07 ##1 !i_reg_wr ##1 i_reg_rd && i_reg_addr == $past(i_reg_addr, 2)
         |=> o_reg_rdata == {23'h0, $past(i_reg_wdata[8:0], 3)};
   endproperty
   a_chan_rd: assert property (p_chan_rd) else $error("channel entry readback");
   property p_pll_rd;
      i_reg_wr && i_reg_addr == 5'h08 ##1 !i_reg_wr ##1 i_reg_rd && i_reg_addr == 5'h08
         |=> o_reg_rdata == {31'h0, $past(i_reg_wdata[0], 3)};
   endproperty
   a_pll_rd: assert property (p_pll_rd) else $error("pll squelch readback");
   property p_lock_rd;
      i_reg_rd && i_reg_addr == 5'h0E && $stable(i_pll_locked) |=> o_reg_rdata[31:30] == $past(i_pll_locked);
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lock status wrong");
   // Overlay selects move only as a result of register writes
   property p_sel_change;
      $changed(o_recov_out_sel) |-> $past(i_reg_wr, 1) || $past(i_reg_wr, 2);
   endproperty
   a_sel_change: assert property (p_sel_change) else $error("overlay select moved alone");
   property p_static_off;
      !o_recov_out_sel[0] && !o_recov_out[0] |=> !o_recov_out[0];
   endproperty
   a_static_off: assert property (p_static_off) else $error("disabled output rose");
   // Clock edges only follow a source tick, so a frozen source means a frozen output
   property p_tick_cause;
      $changed({o_recov_int, o_recov_out}) |-> $past(i_src_tick) != '0;
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("output edge without tick");
   c_status: cover property (i_reg_rd && i_reg_addr == 5'h0E);
   c_int_run: cover property ($rose(o_recov_int[0]));
   c_disable: cover property ($fell(o_recov_out_sel[0]));
endmodule

bind rcs_recov_clock_sel rcs_recov_clock_sel_chk #(.NSRC(NSRC), .NCHAN(NCHAN), .NEXT(NEXT)) chk_u (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_src_tick(i_src_tick),
   .i_pll_locked(i_pll_locked), .o_recov_out(o_recov_out), .o_recov_out_sel(o_recov_out_sel),
   .o_recov_int(o_recov_int));

// *** tb/rcs_src_model.sv ***
`timescale 1ns/100ps

module rcs_src_model #(
   parameter int NSRC = 22
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Controls from the bench
   input wire logic i_slow,
   input wire logic [NSRC-1:0] i_los_set,
   input wire logic [1:0] i_unlock_set,
   // Source side
   output logic [NSRC-1:0] o_src_tick,
   output logic [NSRC-1:0] o_src_los,
   output logic [1:0] o_pll_locked
);
   int cnt_ff [NSRC];
   // Each source ticks every 2, 3 or 4 cycles, set by its index mod 3; slow mode doubles it
   always_ff @(posedge i_sys_clk) begin
      for (int s = 0; s < NSRC; s++) begin
         if (i_reset || cnt_ff[s] == 0) begin
            cnt_ff[s] <= (2 + s % 3) * (i_slow ? 2 : 1) - 1;
         end else begin
            cnt_ff[s] <= cnt_ff[s] - 1;
         end
         o_src_tick[s] <= !i_reset && cnt_ff[s] == 0;
      end
      // Ticks keep coming on loss, as line noise would; only squelch may stop them
      o_src_los <= i_los_set;
      o_pll_locked <= ~i_unlock_set;
   end
endmodule

// *** tb/rcs_recov_clock_sel_tb_top.sv ***
`timescale 1ns/100ps
`include "rcs_params.svh"

module rcs_recov_clock_sel_tb_top;
   logic i_sys_clk;
   logic i_reset;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic slow;
   logic [21:0] los_set;
   logic [1:0] unlock_set;
   logic [31:0] rdata;
   logic [21:0] src_tick;
   logic [21:0] src_los;
   logic [1:0] pll_locked;
   logic [3:0] recov_out;
   logic [3:0] recov_sel;
   logic [3:0] recov_int;
   logic [1:0] pll_out;
   logic [9:0] mon_bits;
   logic mon_last;
   logic [31:0] d;
   int err_count;
   int check_count;
   int cyc;
   int gap;
   int cnt;
   int tgl;
   int t;
   int mon_idx;
   int mon_src;
   int ratio[8] = '{2, 4, 8, 16, 5, 25, 1, 1};
   int sq_src[6] = '{4, 8, 9, 10, 12, 21};
   logic [4:0] sq_a[6] = '{5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h08, 5'h09};
   logic [31:0] sq_en[6] = '{32'h1, 32'h10, 32'h20, 32'h40, 32'h1, 32'h1};

   rcs_src_model #(.NSRC(22)) src_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_slow(slow),
      .i_los_set(los_set), .i_unlock_set(unlock_set), .o_src_tick(src_tick),
      .o_src_los(src_los), .o_pll_locked(pll_locked));
   rcs_recov_clock_sel dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
      .i_src_tick(src_tick), .i_src_los(src_los), .i_pll_locked(pll_locked),
      .o_recov_out(recov_out), .o_recov_out_sel(recov_sel), .o_recov_int(recov_int),
      .o_pll_diff_out(pll_out));
   assign mon_bits = {pll_out, recov_int, recov_out};

   // Clock and cycle ceiling, well above the few thousand cycles the run needs
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   // Ticks between output edges give the half period in source ticks
   always @(negedge i_sys_clk) begin
      if (mon_bits[mon_idx] !== mon_last) begin
         gap = cnt;
         cnt = 0;
         tgl++;
      end
      mon_last = mon_bits[mon_idx];
      if (src_tick[mon_src] === 1'b1) begin
         cnt++;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge i_sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge i_sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      reg_rd <= 1'b0;
      @(negedge i_sys_clk);
      v = rdata;
   endtask
   task automatic cycles(input int n, output int k);
      int t0;
      t0 = tgl;
      repeat (n) @(posedge i_sys_clk);
      k = tgl - t0;
   endtask
   // Bounded wait for four edges, then the last half period must be whole
   task automatic await_gap(input int idx, input int src, input int r);
      int t0;
      int k;
      mon_idx = idx;
      mon_src = src;
      t0 = tgl;
      k = 0;
      while (tgl < t0 + 4 && k < 900) begin
         @(posedge i_sys_clk);
         k++;
      end
      check("half period ticks", gap, r);
   endtask
   task automatic run_ch(input int ch, input int src, input int code, input int r);
      logic [31:0] v;
      logic [31:0] w;
      w = {23'h0, 5'(src), 3'(code), 1'b1};
      wr(5'(ch), w);
      rd(5'(ch), v);
      check("channel entry", v, w);
      await_gap(ch, src, r);
   endtask
   task automatic set_loss(input int src, input logic v);
      @(posedge i_sys_clk);
      if (src == 12) begin
         unlock_set[0] <= v;
      end else if (src == 21) begin
         unlock_set[1] <= v;
      end else begin
         los_set[src] <= v;
      end
   endtask
   // Loss without squelch keeps running, with squelch freezes, then recovers alone
   task automatic sq_case(input int src, input logic [4:0] a, input logic [31:0] en);
      int k;
      logic [31:0] v;
      // Divider code 6 is only legal on an internal channel
      run_ch(4, src, 6, 1);
      set_loss(src, 1'b1);
      cycles(40, k);
      check("edges, squelch off", 32'(k > 0), 1);
      wr(a, en);
      cycles(10, k);
      cycles(60, k);
      check("edges, squelched", k, 0);
      rd(5'h0E, v);
      check("lock status", v[31:30], {src != 21, src != 12});
      set_loss(src, 1'b0);
      cycles(40, k);
      check("edges, restored", 32'(k > 0), 1);
      wr(a, 32'h0);
   endtask

   initial begin
      i_reset = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slow = 1'b0;
      los_set = '0;
      unlock_set = '0;
      repeat (4) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      @(negedge i_sys_clk);
      check("outputs after reset", {18'h0, mon_bits, recov_sel}, 0);
      for (int a = 0; a < 14; a++) begin
         rd(5'(a), d);
         check("reset value", d, 0);
      end
      rd(5'h1F, d);
      check("unmapped read", d, 0);
      // Copper source is silent until its PHY control is filled
      wr(5'h05, 32'h00D);
      mon_idx = 5;
      cycles(60, t);
      check("copper edges, control off", t, 0);
      wr(5'h0B, 32'hD);
      await_gap(5, 0, 1);
      wr(5'h0C, 32'hF);
      run_ch(6, 1, 6, 1);
      for (int c = 0; c < 8; c++) begin
         run_ch(c, 4 + c % 7, c, ratio[c]);
      end
      check("overlay selects", recov_sel, 4'hF);
      run_ch(4, 12, 6, 1);
      slow <= 1'b1;
      run_ch(5, 21, 1, 4);
      slow <= 1'b0;
      wr(5'h00, 32'h0);
      mon_idx = 0;
      repeat (80) @(posedge i_sys_clk);
      cycles(100, t);
      check("edges while disabled", t, 0);
      check("disabled level", {recov_sel[0], recov_out[0]}, 0);
      for (int s = 1; s < 4; s++) begin
         wr(5'h0A, 32'(s));
         await_gap(8, 12, 1 << (s - 1));
      end
      wr(5'h0A, 32'h4);
      await_gap(9, 21, 1);
      wr(5'h0A, 32'h0);
      repeat (20) @(posedge i_sys_clk);
      cycles(60, t);
      check("pll output off", t, 0);
      for (int i = 0; i < 6; i++) begin
         sq_case(sq_src[i], sq_a[i], sq_en[i]);
      end
      close_out();
   end
endmodule
